// ---- verilog/fsp_status_prot.sv ----
// Function
// - busy flag set while an operation runs
// - while busy, accept only status read, suspend
// - operation completion clears the busy flag
// - write enable instruction sets the latch
// - write-type instructions and power-up clear latch
// - three range bits, default protect nothing
// - direction bit picks top or bottom
// - granularity bit picks sectors or blocks
// - invert bit swaps protected and unprotected
// - two lock-mode bits select status protection
// - mode 00 writes need only the latch
// - mode 01, pin low, writes rejected
// - mode 01, pin high, latch allows write
// - mode 10 locked until power cycle
// - mode 11 locks status writes forever
// - suspend sets flag, resume or power clears
// - one-time lock bits set once, never clear
// - four-lane bit turns pins into lanes
// - program/erase into protected area is ignored
// - pin gating only without four lanes
`timescale 1ns/1ps
`default_nettype none

module fsp_status_prot (
    // clock and power-up reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             factory_init,
    // decoded instruction from the serial front end
    input  wire fsp_pkg::fsp_cmd_t cmd,
    output logic                  cmd_accept,
    // array engine
    output logic                  op_start,
    input  wire logic             op_done,
    // write-protect pin, asynchronous, active low
    input  wire logic             wp_n_pin,
    // status and pin function
    output logic [15:0]           status_word,
    output logic                  four_lane_enable,
    output logic                  wp_func_en,
    output logic                  hold_func_en,
    output logic [2:0]            otp_lock
);

    typedef struct packed {
        logic busy;
        logic latch;
        logic sus;
        logic wp_meta;
        logic wp_sync;
        logic op_start;
    } fsp_ctl_t;

    fsp_ctl_t          ctl_r;
    fsp_ctl_t          ctl_nxt;
    fsp_pkg::fsp_nv_t  nv_q;
    fsp_pkg::fsp_nv_t  nv_wr;
    fsp_pkg::fsp_rng_t tgt;
    logic              prot_hit;
    logic              lock_ok;
    logic              otp_hit;
    logic              ok;
    logic              is_wr_st;
    logic              is_array;
    logic              is_sreg;
    logic              wr_st_take;

    ////////////////////////////////////////////////////////////////////////////
    // target region of a program or erase instruction
    function automatic fsp_pkg::fsp_rng_t target_of(input logic [7:0]  code,
                                                    input logic [23:0] addr);
        fsp_pkg::fsp_rng_t r;
        logic [18:0]       span;
        span = fsp_pkg::PAGE_SPAN;
        case (code)
            fsp_pkg::CMD_ER_4K: span = fsp_pkg::SECTOR_SPAN;
            fsp_pkg::CMD_ER_B32: span = fsp_pkg::BLK32_SPAN;
            fsp_pkg::CMD_ER_B64: span = fsp_pkg::BLK64_SPAN;
            fsp_pkg::CMD_ER_CHIP,
            fsp_pkg::CMD_ER_CHIP2: span = fsp_pkg::ARRAY_LAST;
            default: span = fsp_pkg::PAGE_SPAN;
        endcase
        r.lo = addr[18:0] & ~span;
        r.hi = r.lo | span;
        return r;
    endfunction

    function automatic logic array_op(input logic [7:0] code);
        case (code)
            fsp_pkg::CMD_PROG, fsp_pkg::CMD_QPROG, fsp_pkg::CMD_ER_4K,
            fsp_pkg::CMD_ER_B32, fsp_pkg::CMD_ER_B64, fsp_pkg::CMD_ER_CHIP,
            fsp_pkg::CMD_ER_CHIP2: array_op = 1'b1;
            default: array_op = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // submodules
    fsp_prot_map u_map (
        .nv  (nv_q),
        .tgt (tgt),
        .hit (prot_hit)
    );

    fsp_nv_store u_nv (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .factory_init (factory_init),
        .wr_en        (wr_st_take),
        .wr_val       (nv_wr),
        .nv_q         (nv_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // acceptance
    always_comb begin
        tgt      = target_of(cmd.code, cmd.addr);
        is_wr_st = (cmd.code == fsp_pkg::CMD_WR_ST);
        is_array = array_op(cmd.code);
        is_sreg  = (cmd.code == fsp_pkg::CMD_ER_SREG) || (cmd.code == fsp_pkg::CMD_PR_SREG);
        case (cmd.addr[13:12])
            2'h1: otp_hit = nv_q.otp[0];
            2'h2: otp_hit = nv_q.otp[1];
            2'h3: otp_hit = nv_q.otp[2];
            default: otp_hit = 1'b1;
        endcase
        case (nv_q.lock)
            fsp_pkg::LOCK_SW: lock_ok = 1'b1;
            fsp_pkg::LOCK_HW: lock_ok = nv_q.quad || ctl_r.wp_sync;
            default:          lock_ok = 1'b0;
        endcase
        ok = 1'b0;
        if (ctl_r.busy) begin
            ok = (cmd.code == fsp_pkg::CMD_RD_ST1) || (cmd.code == fsp_pkg::CMD_RD_ST2)
                 || ((cmd.code == fsp_pkg::CMD_SUSPEND) && !ctl_r.sus);
        end else begin
            case (cmd.code)
                fsp_pkg::CMD_WR_EN, fsp_pkg::CMD_WR_DIS,
                fsp_pkg::CMD_RD_ST1, fsp_pkg::CMD_RD_ST2: ok = 1'b1;
                fsp_pkg::CMD_RESUME: ok = ctl_r.sus;
                fsp_pkg::CMD_WR_ST: ok = ctl_r.latch && lock_ok;
                fsp_pkg::CMD_ER_SREG,
                fsp_pkg::CMD_PR_SREG: ok = ctl_r.latch && !otp_hit;
                default: ok = is_array && ctl_r.latch && !prot_hit;
            endcase
        end
        cmd_accept = cmd.valid && ok;
        wr_st_take = cmd_accept && is_wr_st;
        nv_wr        = nv_q;
        nv_wr.range  = cmd.data[fsp_pkg::ST_RANGE +: 3];
        nv_wr.dir    = cmd.data[fsp_pkg::ST_DIR];
        nv_wr.gran   = cmd.data[fsp_pkg::ST_GRAN];
        nv_wr.lock   = fsp_pkg::fsp_lock_t'({cmd.data[fsp_pkg::ST_LOCK_HI],
                                            cmd.data[fsp_pkg::ST_LOCK_LO]});
        nv_wr.quad   = cmd.data[fsp_pkg::ST_QUAD];
        nv_wr.otp    = cmd.data[fsp_pkg::ST_OTP +: 3];
        nv_wr.invert = cmd.data[fsp_pkg::ST_INV];
    end

    ////////////////////////////////////////////////////////////////////////////
    // volatile state
    always_comb begin
        ctl_nxt          = ctl_r;
        // raw pin goes straight into the first flop; high means writes allowed
        ctl_nxt.wp_meta  = wp_n_pin;
        ctl_nxt.wp_sync  = ctl_r.wp_meta;
        ctl_nxt.op_start = 1'b0;
        if (op_done && ctl_r.busy) begin
            ctl_nxt.busy = 1'b0;
        end
        if (cmd_accept) begin
            case (cmd.code)
                fsp_pkg::CMD_WR_EN: ctl_nxt.latch = 1'b1;
                fsp_pkg::CMD_WR_DIS: ctl_nxt.latch = 1'b0;
                fsp_pkg::CMD_SUSPEND: begin
                    ctl_nxt.sus  = 1'b1;
                    ctl_nxt.busy = 1'b0;
                end
                fsp_pkg::CMD_RESUME: begin
                    ctl_nxt.sus  = 1'b0;
                    ctl_nxt.busy = 1'b1;
                end
                fsp_pkg::CMD_RD_ST1, fsp_pkg::CMD_RD_ST2: ctl_nxt.busy = ctl_nxt.busy;
                default: begin
                    ctl_nxt.busy     = 1'b1;
                    ctl_nxt.latch    = 1'b0;
                    ctl_nxt.op_start = 1'b1;
                end
            endcase
        end
        if (sys_rst) begin
            ctl_nxt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        ctl_r <= ctl_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign op_start         = ctl_r.op_start;
    assign four_lane_enable = nv_q.quad;
    assign wp_func_en       = !nv_q.quad;
    assign hold_func_en     = !nv_q.quad;
    assign otp_lock         = nv_q.otp;
    assign status_word      = {ctl_r.sus, nv_q.invert, nv_q.otp, 1'b0, nv_q.quad,
                               nv_q.lock, nv_q.gran, nv_q.dir, nv_q.range,
                               ctl_r.latch, ctl_r.busy};

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_busy_set: assert property (cmd_accept && (is_array || is_wr_st || is_sreg)
        |=> ctl_r.busy && op_start)
        else $error("busy not raised for accepted operation");

    chk_busy_filter: assert property (ctl_r.busy && cmd.valid
        && (cmd.code == fsp_pkg::CMD_WR_EN || is_wr_st || is_array) |-> !cmd_accept)
        else $error("instruction taken while busy");

    chk_busy_clear: assert property (ctl_r.busy && op_done && !cmd_accept
        |=> !status_word[fsp_pkg::ST_BUSY])
        else $error("busy not cleared on completion");

    chk_latch_set: assert property (cmd_accept && cmd.code == fsp_pkg::CMD_WR_EN
        |=> status_word[fsp_pkg::ST_LATCH])
        else $error("latch not set by write enable");

    chk_latch_clear: assert property (cmd_accept && (is_wr_st || is_array || is_sreg
        || cmd.code == fsp_pkg::CMD_WR_DIS) |=> !ctl_r.latch)
        else $error("latch not cleared");

    chk_hw_lock: assert property (nv_q.lock == fsp_pkg::LOCK_HW && !nv_q.quad
        && $past(wp_n_pin, 3) == 1'b0 && $past(wp_n_pin, 2) == 1'b0 && is_wr_st |-> !cmd_accept)
        else $error("status write taken with pin low");

    chk_perm_lock: assert property (nv_q.lock[1] && is_wr_st |-> !cmd_accept)
        else $error("status write taken under lock");

    chk_sus_set: assert property (cmd_accept && cmd.code == fsp_pkg::CMD_SUSPEND
        |=> status_word[fsp_pkg::ST_SUS] && !status_word[fsp_pkg::ST_BUSY])
        else $error("suspend flag not set");

    chk_prot_block: assert property (is_array && prot_hit |-> !cmd_accept ##1 !op_start)
        else $error("protected region operation taken");

    chk_rsvd_zero: assert property (!status_word[fsp_pkg::ST_RSVD])
        else $error("reserved status bit not zero");

    chk_latch_hold: assert property (!cmd_accept |=> $stable(ctl_r.latch))
        else $error("latch changed without an instruction");

    chk_lock_soft: assert property (nv_q.lock == fsp_pkg::LOCK_SW && ctl_r.latch
        && !ctl_r.busy && cmd.valid && is_wr_st |-> cmd_accept)
        else $error("status write refused in software mode");

    // pin level two edges back is what the lock check sees, unless reset flushed it
    chk_hw_open: assert property (nv_q.lock == fsp_pkg::LOCK_HW && ctl_r.latch
        && !ctl_r.busy && cmd.valid && is_wr_st && $past(wp_n_pin, 2)
        && !$past(sys_rst) && !$past(sys_rst, 2) |-> cmd_accept)
        else $error("status write refused with pin high");

    chk_quad_open: assert property (nv_q.lock == fsp_pkg::LOCK_HW && nv_q.quad
        && ctl_r.latch && !ctl_r.busy && cmd.valid && is_wr_st |-> cmd_accept)
        else $error("pin gated status write with four lanes on");

    chk_pwr_release: assert property (disable iff (factory_init)
        sys_rst && nv_q.lock == fsp_pkg::LOCK_PWR |=> nv_q.lock == fsp_pkg::LOCK_SW)
        else $error("lock-down not released by power cycle");

    chk_resume: assert property (cmd_accept && cmd.code == fsp_pkg::CMD_RESUME
        |=> !status_word[fsp_pkg::ST_SUS] && status_word[fsp_pkg::ST_BUSY])
        else $error("resume did not restart the operation");

    chk_power_clear: assert property (disable iff (factory_init) sys_rst
        |=> !status_word[fsp_pkg::ST_SUS] && !status_word[fsp_pkg::ST_LATCH]
        && !status_word[fsp_pkg::ST_BUSY])
        else $error("power cycle left volatile flags set");

    chk_otp_gate: assert property (is_sreg && cmd.addr[13:12] == 2'h1 && nv_q.otp[0]
        |-> !cmd_accept)
        else $error("locked security register written");

    chk_otp_merge: assert property (wr_st_take |=> status_word[fsp_pkg::ST_OTP +: 3]
        == ($past(nv_q.otp) | $past(cmd.data[fsp_pkg::ST_OTP +: 3])))
        else $error("one-time lock bits not merged");

    chk_nv_write: assert property (wr_st_take
        |=> status_word[fsp_pkg::ST_QUAD:fsp_pkg::ST_RANGE]
            == $past(cmd.data[fsp_pkg::ST_QUAD:fsp_pkg::ST_RANGE])
        && status_word[fsp_pkg::ST_INV] == $past(cmd.data[fsp_pkg::ST_INV]))
        else $error("protection fields not stored");

    chk_busy_hold: assert property (ctl_r.busy && !op_done && !cmd_accept
        |=> ctl_r.busy)
        else $error("busy dropped while operation runs");

endmodule

`default_nettype wire

// ---- verilog/fsp_pkg.sv ----
package fsp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // array geometry, 512 KB
    localparam int          ADDR_W      = 19;
    localparam logic [18:0] ARRAY_LAST  = 19'h7ffff;
    localparam logic [18:0] PAGE_SPAN   = 19'h000ff;
    localparam logic [18:0] SECTOR_SPAN = 19'h00fff;
    localparam logic [18:0] BLK32_SPAN  = 19'h07fff;
    localparam logic [18:0] BLK64_SPAN  = 19'h0ffff;
    localparam logic [18:0] SECTOR_SIZE = 19'h01000;
    localparam logic [18:0] BLK64_SIZE  = 19'h10000;
    localparam logic [18:0] CAP32_SIZE  = 19'h08000;

    ////////////////////////////////////////////////////////////////////////////
    // instruction codes
    localparam logic [7:0] CMD_WR_EN    = 8'h06;
    localparam logic [7:0] CMD_WR_DIS   = 8'h04;
    localparam logic [7:0] CMD_RD_ST1   = 8'h05;
    localparam logic [7:0] CMD_RD_ST2   = 8'h35;
    localparam logic [7:0] CMD_WR_ST    = 8'h01;
    localparam logic [7:0] CMD_PROG     = 8'h02;
    localparam logic [7:0] CMD_QPROG    = 8'h32;
    localparam logic [7:0] CMD_ER_4K    = 8'h20;
    localparam logic [7:0] CMD_ER_B32   = 8'h52;
    localparam logic [7:0] CMD_ER_B64   = 8'hd8;
    localparam logic [7:0] CMD_ER_CHIP  = 8'hc7;
    localparam logic [7:0] CMD_ER_CHIP2 = 8'h60;
    localparam logic [7:0] CMD_ER_SREG  = 8'h44;
    localparam logic [7:0] CMD_PR_SREG  = 8'h42;
    localparam logic [7:0] CMD_SUSPEND  = 8'h75;
    localparam logic [7:0] CMD_RESUME   = 8'h7a;

    ////////////////////////////////////////////////////////////////////////////
    // status word bit positions
    localparam int ST_BUSY    = 0;
    localparam int ST_LATCH   = 1;
    localparam int ST_RANGE   = 2;
    localparam int ST_DIR     = 5;
    localparam int ST_GRAN    = 6;
    localparam int ST_LOCK_LO = 7;
    localparam int ST_LOCK_HI = 8;
    localparam int ST_QUAD    = 9;
    localparam int ST_RSVD    = 10;
    localparam int ST_OTP     = 11;
    localparam int ST_INV     = 14;
    localparam int ST_SUS     = 15;

    typedef enum logic [1:0] {
        LOCK_SW  = 2'b00,
        LOCK_HW  = 2'b01,
        LOCK_PWR = 2'b10,
        LOCK_OTP = 2'b11
    } fsp_lock_t;

    typedef struct packed {
        logic       invert;
        logic [2:0] otp;
        logic       quad;
        fsp_lock_t  lock;
        logic       gran;
        logic       dir;
        logic [2:0] range;
    } fsp_nv_t;

    localparam fsp_nv_t NV_FACTORY = '0;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] data;
        logic [23:0] addr;
    } fsp_cmd_t;

    typedef struct packed {
        logic [18:0] lo;
        logic [18:0] hi;
    } fsp_rng_t;

endpackage

// ---- verilog/fsp_nv_store.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsp_nv_store (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            sys_rst,
    input  wire logic            factory_init,
    // write port
    input  wire logic            wr_en,
    input  wire fsp_pkg::fsp_nv_t wr_val,
    // stored bits
    output fsp_pkg::fsp_nv_t      nv_q
);

    fsp_pkg::fsp_nv_t nv_r;
    fsp_pkg::fsp_nv_t nv_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // power cycle leaves the bits alone except the lock-down release
    always_comb begin
        nv_nxt = nv_r;
        if (factory_init) begin
            nv_nxt = fsp_pkg::NV_FACTORY;
        end else if (sys_rst) begin
            if (nv_r.lock == fsp_pkg::LOCK_PWR) begin
                nv_nxt.lock = fsp_pkg::LOCK_SW;
            end
        end else if (wr_en) begin
            nv_nxt     = wr_val;
            nv_nxt.otp = nv_r.otp | wr_val.otp;
        end
    end

    always_ff @(posedge ref_clk) begin
        nv_r <= nv_nxt;
    end

    assign nv_q = nv_r;

    ////////////////////////////////////////////////////////////////////////////
    chk_otp_sticky: assert property (@(posedge ref_clk) disable iff (factory_init)
        ((nv_r.otp & $past(nv_r.otp)) == $past(nv_r.otp)))
        else $error("one-time lock bit was cleared");

endmodule

`default_nettype wire

// ---- verilog/fsp_prot_map.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsp_prot_map (
    // protection fields
    input  wire fsp_pkg::fsp_nv_t nv,
    // target region of a program or erase
    input  wire fsp_pkg::fsp_rng_t tgt,
    // target touches protected data
    output logic                  hit
);

    logic        none;
    logic [18:0] size;
    logic [18:0] lo;
    logic [18:0] hi;
    logic        overlap;
    logic        outside;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        none = (nv.range == 3'h0);
        size = fsp_pkg::ARRAY_LAST;
        if (!nv.gran) begin
            if (!nv.range[2]) begin
                size = 19'(fsp_pkg::BLK64_SIZE << (nv.range[1:0] - 2'h1));
            end
        end else if (nv.range == 3'h7) begin
            size = fsp_pkg::ARRAY_LAST;
        end else if (nv.range[2]) begin
            size = fsp_pkg::CAP32_SIZE;
        end else begin
            size = 19'(fsp_pkg::SECTOR_SIZE << (nv.range[1:0] - 2'h1));
        end
        if (size == fsp_pkg::ARRAY_LAST) begin
            lo = '0;
            hi = fsp_pkg::ARRAY_LAST;
        end else if (nv.dir) begin
            lo = '0;
            hi = 19'(size - 19'h1);
        end else begin
            lo = 19'(fsp_pkg::ARRAY_LAST - size + 19'h1);
            hi = fsp_pkg::ARRAY_LAST;
        end
        overlap = !none && (tgt.lo <= hi) && (tgt.hi >= lo);
        outside = none || (tgt.lo < lo) || (tgt.hi > hi);
        hit     = nv.invert ? outside : overlap;
    end

endmodule

`default_nettype wire

// ---- dv/fsp_eng_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fsp_eng_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // engine handshake
    input  wire logic op_start,
    input  wire logic slow,
    input  wire logic hold,
    output logic      op_done
);
    int cnt;

    // array engine: finishes after 1 or 20 cycles, frozen while suspended
    always_ff @(posedge ref_clk) begin
        op_done <= 1'b0;
        if (sys_rst) begin
            cnt <= 0;
        end else if (op_start) begin
            cnt <= slow ? 20 : 1;
        end else if (hold) begin
            cnt <= cnt;
        end else if (cnt == 1) begin
            op_done <= 1'b1;
            cnt     <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              factory_init = 1'b1;
    logic              wp_n_pin = 1'b1;
    logic              slow = 1'b0;
    fsp_pkg::fsp_cmd_t cmd = '0;
    logic              cmd_accept;
    logic              op_start;
    logic              op_done;
    logic [15:0]       sw;
    logic              four_lane_enable;
    logic              wp_func_en;
    logic              hold_func_en;
    logic [2:0]        otp_lock;
    int                failures = 0;
    int                tests_run = 0;

    always #5 ref_clk = ~ref_clk;

    fsp_status_prot dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .factory_init(factory_init),
        .cmd(cmd), .cmd_accept(cmd_accept), .op_start(op_start), .op_done(op_done),
        .wp_n_pin(wp_n_pin), .status_word(sw), .four_lane_enable(four_lane_enable),
        .wp_func_en(wp_func_en), .hold_func_en(hold_func_en), .otp_lock(otp_lock)
    );

    fsp_eng_model eng (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .op_start(op_start),
        .slow(slow), .hold(sw[15]), .op_done(op_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // one instruction: held one cycle, accept sampled before the taking edge
    task automatic issue(input logic [7:0] c, input logic [15:0] d, input logic [23:0] ad,
                         output logic acc);
        @(posedge ref_clk);
        #1;
        cmd = '{valid: 1'b1, code: c, data: d, addr: ad};
        #8;
        acc = cmd_accept;
        @(posedge ref_clk);
        #1;
        cmd.valid = 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (sw[0] !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk_bit(sw[0], 1'b0, "busy never cleared");
    endtask

    task automatic wrst(input logic [15:0] d, input logic exp);
        logic a;
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        issue(fsp_pkg::CMD_WR_ST, d, 24'h0, a);
        chk_bit(a, exp, "status write accept");
        if (a) wait_idle();
    endtask

    task automatic prot(input logic [15:0] d, input logic [23:0] ad, input logic exp);
        logic a;
        wrst(d, 1'b1);
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        issue(fsp_pkg::CMD_PROG, 16'h0000, ad, a);
        chk_bit(a, exp, "program accept vs protection");
        chk_bit(op_start, exp, "engine start vs protection");
        if (a) wait_idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        chk_word(sw, 16'h0000, "factory status");
        chk_bit(four_lane_enable, 1'b0, "four lane default");
        chk_bit(wp_func_en, 1'b1, "wp function default");
        chk_bit(hold_func_en, 1'b1, "pause function default");
        $display("done defaults");
    endtask

    task automatic t_busy();
        logic a;
        slow = 1'b1;
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        chk_bit(sw[1], 1'b1, "latch set");
        issue(fsp_pkg::CMD_WR_DIS, 16'h0000, 24'h0, a);
        chk_bit(sw[1], 1'b0, "latch cleared by disable");
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        issue(fsp_pkg::CMD_PROG, 16'h0000, 24'h001000, a);
        chk_bit(sw[0], 1'b1, "busy while programming");
        chk_bit(op_start, 1'b1, "engine start pulse");
        chk_bit(sw[1], 1'b0, "latch cleared by program");
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        chk_bit(a, 1'b0, "enable ignored while busy");
        issue(fsp_pkg::CMD_RD_ST1, 16'h0000, 24'h0, a);
        chk_bit(a, 1'b1, "status read while busy");
        issue(fsp_pkg::CMD_RD_ST2, 16'h0000, 24'h0, a);
        chk_bit(a, 1'b1, "second status read while busy");
        wait_idle();
        chk_bit(sw[1], 1'b0, "latch stays clear");
        slow = 1'b0;
        $display("done busy");
    endtask

    task automatic t_suspend();
        logic a;
        slow = 1'b1;
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        issue(fsp_pkg::CMD_ER_4K, 16'h0000, 24'h002000, a);
        issue(fsp_pkg::CMD_RESUME, 16'h0000, 24'h0, a);
        chk_bit(a, 1'b0, "resume refused when not suspended");
        issue(fsp_pkg::CMD_SUSPEND, 16'h0000, 24'h0, a);
        chk_bit(sw[15], 1'b1, "suspend flag set");
        chk_bit(sw[0], 1'b0, "busy off while suspended");
        issue(fsp_pkg::CMD_RESUME, 16'h0000, 24'h0, a);
        chk_bit(sw[15], 1'b0, "suspend flag cleared");
        chk_bit(sw[0], 1'b1, "busy again after resume");
        wait_idle();
        slow = 1'b0;
        $display("done suspend");
    endtask

    task automatic t_prot();
        prot(16'h0004, 24'h070000, 1'b0);
        prot(16'h0004, 24'h060000, 1'b1);
        prot(16'h0024, 24'h000000, 1'b0);
        prot(16'h0024, 24'h070000, 1'b1);
        prot(16'h0044, 24'h07f000, 1'b0);
        prot(16'h0044, 24'h07e000, 1'b1);
        prot(16'h4004, 24'h070000, 1'b1);
        prot(16'h4004, 24'h000000, 1'b0);
        $display("done protection");
    endtask

    task automatic t_otp();
        logic a;
        wrst(16'h0800, 1'b1);
        wrst(16'h8403, 1'b1);
        chk_word(sw, 16'h0800, "reserved and read-only bits ignored");
        chk_bit(otp_lock[0], 1'b1, "lock bit never clears");
        issue(fsp_pkg::CMD_WR_EN, 16'h0000, 24'h0, a);
        issue(fsp_pkg::CMD_ER_SREG, 16'h0000, 24'h001000, a);
        chk_bit(a, 1'b0, "locked security register erase");
        issue(fsp_pkg::CMD_ER_SREG, 16'h0000, 24'h002000, a);
        chk_bit(a, 1'b1, "unlocked security register erase");
        wait_idle();
        $display("done otp");
    endtask

    task automatic pin(input logic v);
        wp_n_pin = v;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic pwr_cycle();
        sys_rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
    endtask

    task automatic t_lock();
        logic a;
        issue(fsp_pkg::CMD_WR_ST, 16'h0000, 24'h0, a);
        chk_bit(a, 1'b0, "write without latch");
        wrst(16'h0080, 1'b1);
        pin(1'b0);
        wrst(16'h0000, 1'b0);
        pin(1'b1);
        wrst(16'h0280, 1'b1);
        chk_bit(four_lane_enable, 1'b1, "four lanes on");
        chk_bit(wp_func_en | hold_func_en, 1'b0, "pin functions off");
        pin(1'b0);
        wrst(16'h0080, 1'b1);
        pin(1'b1);
        wrst(16'h0100, 1'b1);
        wrst(16'h0000, 1'b0);
        pwr_cycle();
        chk_word(sw, 16'h0800, "lock-down released by power cycle");
        wrst(16'h0180, 1'b1);
        wrst(16'h0000, 1'b0);
        pwr_cycle();
        chk_word(sw, 16'h0980, "permanent lock survives power cycle");
        wrst(16'h0000, 1'b0);
        $display("done lock");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        factory_init = 1'b0;
        @(posedge ref_clk);
        #1;
        t_defaults();
        t_busy();
        t_suspend();
        t_prot();
        t_otp();
        t_lock();
        end_of_test();
    end

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire
